// file: shared/ahf_pkg.sv
/*
 package for the fifo host controller: pin timing counts, word width, carriers.
 assumes a 100 MHz ref_clk; every cycle count is derived from a time in ns.
*/
`default_nettype none
package ahf_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int WORD_W = 5;
    localparam int DEPTH = 64;
    localparam int CNT_W = 7;
    // pin times in ns as printed for the slowest grade
    localparam int MR_PULSE_NS = 30;
    localparam int MR_TO_SI_NS = 35;
    localparam int SI_HIGH_NS = 23;
    localparam int SI_LOW_NS = 30;
    localparam int DATA_HOLD_NS = 40;
    localparam int SO_HIGH_NS = 23;
    localparam int SO_LOW_NS = 25;
    localparam int SETUP_OR_NS = 2;
    // least times round up to whole cycles
    localparam int MR_PULSE_CYC = (MR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MR_TO_SI_CYC = (MR_TO_SI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SI_HIGH_CYC = (SI_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SI_LOW_CYC = (SI_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SO_HIGH_CYC = (SO_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SO_LOW_CYC = (SO_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_OR_CYC = (SETUP_OR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 4;
    localparam logic [TMR_W-1:0] TMR_ZERO = 4'h0;
    localparam logic [TMR_W-1:0] TMR_ONE = 4'h1;

    typedef logic [WORD_W-1:0] ahf_word_t;

    // pins toward the fifo
    typedef struct packed {
        logic master_reset_n;
        logic shift_in;
        ahf_word_t write_data_in;
        logic shift_out;
        logic output_enable_n;
    } ahf_pins_out_t;

    // pins from the fifo
    typedef struct packed {
        logic input_ready;
        logic output_ready;
        ahf_word_t read_data_out;
    } ahf_pins_in_t;

    typedef enum logic [4:0] {
        WR_RESET = 5'h01,
        WR_GAP = 5'h02,
        WR_IDLE = 5'h04,
        WR_HIGH = 5'h08,
        WR_LOW = 5'h10
    } ahf_wr_state_t;

    typedef enum logic [3:0] {
        RD_WAIT = 4'h1,
        RD_TAKE = 4'h2,
        RD_HIGH = 4'h4,
        RD_LOW = 4'h8
    } ahf_rd_state_t;
endpackage
`default_nettype wire

// file: hdl/ahf_host.sv
/*
 host controller for a 64-word strobe handshake fifo: drives master reset,
 shift-in and shift-out, and moves words between two valid/ready streams.
 assumes the fifo pins are synchronous to ref_clk and the fifo is a 64 deep part.
*/
// Contract
// - pulse master reset before any shift
// - full-wait writer holds data around ready
// - writer holds data through hold time
// - wide stacking ANDs ready flags
// - depth cascade ties ready to strobes
`timescale 1ns/100ps
`default_nettype none
module ahf_host
    import ahf_pkg::*;
(
    input wire logic ref_clk, // 100 MHz clock
    input wire logic arst_n, // async reset, active low
    input wire ahf_pkg::ahf_word_t src_data, // word to push
    input wire logic src_valid, // push request
    output logic src_ready, // buffer can take a word
    output ahf_pkg::ahf_word_t snk_data, // word popped
    output logic snk_valid, // popped word present
    input wire logic snk_ready, // receiver takes word
    input wire logic reset_req, // request a fifo master reset
    output ahf_pkg::ahf_pins_out_t fifo_out, // strobes and data to fifo
    input wire ahf_pkg::ahf_pins_in_t fifo_in, // flags and data from fifo
    output logic [CNT_W-1:0] level // words the host thinks are inside
);
    import ahf_pkg::*;

    logic rst_s1_reg, rst_s2_reg;
    // reset release through two flops
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    wire logic rst_n = rst_s2_reg;

    function automatic logic [TMR_W-1:0] cyc(input int n);
        cyc = TMR_W'(n);
    endfunction

    // two-entry skid buffer on the read side
    ahf_word_t buf_reg [2];
    ahf_word_t buf_next [2];
    logic [1:0] bcnt_reg, bcnt_next;
    logic push;
    logic pop;
    assign snk_valid = (bcnt_reg != 2'h0);
    assign snk_data = buf_reg[0];
    assign pop = snk_valid && snk_ready;
    always_comb
    begin
        buf_next = buf_reg;
        bcnt_next = bcnt_reg;
        if (pop)
        begin
            buf_next[0] = buf_reg[1];
            bcnt_next = bcnt_next - 2'h1;
        end
        if (push)
        begin
            buf_next[bcnt_next[0]] = fifo_in.read_data_out;
            bcnt_next = bcnt_next + 2'h1;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            buf_reg[0] <= '0;
            buf_reg[1] <= '0;
            bcnt_reg <= 2'h0;
        end
        else
        begin
            buf_reg <= buf_next;
            bcnt_reg <= bcnt_next;
        end
    end

    // writer: master reset, then shift-in strobes
    ahf_wr_state_t wst_reg, wst_next;
    logic [TMR_W-1:0] wt_reg, wt_next;
    logic mr_n_reg, mr_n_next, si_reg, si_next;
    ahf_word_t wd_reg, wd_next;
    logic [CNT_W-1:0] lvl_reg, lvl_next;
    logic wr_done, rd_done;
    // a single part sets the width, so its own flag is the composite one
    assign src_ready = (wst_reg == WR_IDLE) && fifo_in.input_ready;
    always_comb
    begin
        wst_next = wst_reg;
        wt_next = (wt_reg != TMR_ZERO) ? wt_reg - TMR_ONE : TMR_ZERO;
        mr_n_next = mr_n_reg;
        si_next = si_reg;
        wd_next = wd_reg;
        wr_done = 1'b0;
        case (wst_reg)
            WR_RESET:
            begin
                mr_n_next = 1'b0;
                si_next = 1'b0; // shift-in low at release
                if (wt_reg == TMR_ZERO)
                begin
                    mr_n_next = 1'b1;
                    wt_next = cyc(MR_TO_SI_CYC);
                    wst_next = WR_GAP;
                end
            end
            WR_GAP:
                if (wt_reg == TMR_ZERO)
                    wst_next = WR_IDLE;
            WR_IDLE:
                if (src_valid && fifo_in.input_ready)
                begin
                    wd_next = src_data; // data registered in the same cycle as the rise
                    si_next = 1'b1;
                    wt_next = cyc(HOLD_CYC > SI_HIGH_CYC ? HOLD_CYC : SI_HIGH_CYC);
                    wst_next = WR_HIGH;
                end
            WR_HIGH:
                // wait for ready to drop and the hold time before the fall
                if (wt_reg == TMR_ZERO && !fifo_in.input_ready)
                begin
                    si_next = 1'b0;
                    wr_done = 1'b1;
                    wt_next = cyc(SI_LOW_CYC);
                    wst_next = WR_LOW;
                end
            WR_LOW:
                if (wt_reg == TMR_ZERO)
                    wst_next = WR_IDLE;
            default:
                wst_next = WR_RESET;
        endcase
        if (reset_req)
        begin
            wst_next = WR_RESET;
            mr_n_next = 1'b0;
            si_next = 1'b0;
            wt_next = cyc(MR_PULSE_CYC);
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wst_reg <= WR_RESET;
            wt_reg <= TMR_W'(MR_PULSE_CYC);
            mr_n_reg <= 1'b0;
            si_reg <= 1'b0;
            wd_reg <= '0;
        end
        else
        begin
            wst_reg <= wst_next;
            wt_reg <= wt_next;
            mr_n_reg <= mr_n_next;
            si_reg <= si_next;
            wd_reg <= wd_next;
        end
    end

    // reader: take a word while output ready, then strobe shift-out
    ahf_rd_state_t rst_reg, rst_next;
    logic [TMR_W-1:0] rt_reg, rt_next;
    logic so_reg, so_next;
    logic fifo_live;
    assign fifo_live = (wst_reg != WR_RESET) && (wst_reg != WR_GAP);
    always_comb
    begin
        rst_next = rst_reg;
        rt_next = (rt_reg != TMR_ZERO) ? rt_reg - TMR_ONE : TMR_ZERO;
        so_next = so_reg;
        push = 1'b0;
        rd_done = 1'b0;
        case (rst_reg)
            RD_WAIT:
                // output ready high means stable data; room needed so no word is lost
                // fetch only on output ready, as a cascaded receiver would
                if (fifo_live && fifo_in.output_ready && bcnt_reg == 2'h0)
                begin
                    rt_next = cyc(SETUP_OR_CYC);
                    rst_next = RD_TAKE;
                end
            RD_TAKE:
                if (rt_reg == TMR_ZERO)
                begin
                    push = 1'b1; // words taken in order
                    so_next = 1'b1;
                    rt_next = cyc(SO_HIGH_CYC);
                    rst_next = RD_HIGH;
                end
            RD_HIGH:
                // wait for ready to fall before ending the strobe
                if (rt_reg == TMR_ZERO && !fifo_in.output_ready)
                begin
                    so_next = 1'b0;
                    rd_done = 1'b1;
                    rt_next = cyc(SO_LOW_CYC);
                    rst_next = RD_LOW;
                end
            RD_LOW:
                if (rt_reg == TMR_ZERO)
                    rst_next = RD_WAIT;
            default:
                rst_next = RD_WAIT;
        endcase
        if (!fifo_live)
        begin
            so_next = 1'b0;
            rst_next = RD_WAIT;
            push = 1'b0;
            rd_done = 1'b0;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_reg <= RD_WAIT;
            rt_reg <= TMR_ZERO;
            so_reg <= 1'b0;
        end
        else
        begin
            rst_reg <= rst_next;
            rt_reg <= rt_next;
            so_reg <= so_next;
        end
    end

    // host-side occupancy estimate
    always_comb
    begin
        lvl_next = lvl_reg;
        if (!fifo_live)
            lvl_next = '0;
        else if (wr_done && !rd_done)
            lvl_next = lvl_reg + 7'h01;
        else if (rd_done && !wr_done)
            lvl_next = lvl_reg - 7'h01;
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            lvl_reg <= '0;
        else
            lvl_reg <= lvl_next;
    end

    assign level = lvl_reg;
    assign fifo_out.master_reset_n = mr_n_reg;
    assign fifo_out.shift_in = si_reg;
    assign fifo_out.write_data_in = wd_reg; // held stable through the strobe
    assign fifo_out.shift_out = so_reg;
    assign fifo_out.output_enable_n = 1'b0; // sole reader keeps the bus driven
endmodule
`default_nettype wire

// file: tb/ahf_fifo_model.sv
/*
 behavioural 64-word strobe fifo facing the host controller.
 assumes pins are sampled on ref_clk; stall delays flag rises at random.
*/
`timescale 1ns/100ps
`default_nettype none
module ahf_fifo_model
    import ahf_pkg::*;
(
    input wire logic ref_clk, // host clock
    input wire ahf_pkg::ahf_pins_out_t pins, // strobes from host
    input wire logic stall, // slows flag rises
    output ahf_pkg::ahf_pins_in_t fifo, // flags and data to host
    output logic [ahf_pkg::CNT_W-1:0] count // words stored
);
    ahf_word_t mem [DEPTH];
    ahf_word_t dout;
    logic [5:0] wp;
    logic [5:0] rp;
    logic si_q;
    logic so_q;
    logic mr_q;
    logic ir;
    logic orr;
    // store step per clock; output ready rises once the word has settled, except the arrival pulse under a held shift-out
    always @(posedge ref_clk)
    begin
        logic [CNT_W-1:0] n;
        logic [5:0] r;
        n = count;
        r = rp;
        si_q <= pins.shift_in;
        so_q <= pins.shift_out;
        mr_q <= pins.master_reset_n;
        if (!pins.master_reset_n)
        begin
            count <= '0;
            wp <= '0;
            rp <= '0;
            dout <= '0;
            ir <= 1'b1;
            orr <= 1'b0;
        end
        else
        begin
            // shift-in already high as reset ends also writes the word
            if (pins.shift_in && (!si_q || !mr_q) && n < DEPTH)
                mem[wp] <= pins.write_data_in;
            if (!pins.shift_in && si_q && n < DEPTH)
            begin
                wp <= wp + 6'h1;
                n = n + 1'b1;
            end
            if (!pins.shift_out && so_q && n != 0)
            begin
                r = rp + 6'h1;
                n = n - 1'b1;
            end
            if (n != 0)
                dout <= mem[r];
            rp <= r;
            count <= n;
            ir <= !pins.shift_in && n < DEPTH && (ir || !stall);
            // shift-out held high over an empty store: one cycle pulse on arrival
            orr <= (!pins.shift_out && n != 0 && dout === mem[r] && (orr || !stall))
                || (pins.shift_out && count == '0 && n != 0);
        end
    end
    // a disabled bus shows the inverse so a stale sample cannot pass
    assign fifo = '{ir, orr, pins.output_enable_n ? ~dout : dout};
endmodule
`default_nettype wire

// file: tb/ahf_host_asserts.sv
/*
 pin protocol checks for the fifo host controller.
 assumes it is bound to ahf_host and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module ahf_host_asserts
    import ahf_pkg::*;
(
    input wire logic ref_clk, // clock
    input wire logic arst_n, // async reset
    input wire logic src_valid, // push request
    input wire logic src_ready, // push accept
    input wire ahf_pkg::ahf_word_t snk_data, // popped word
    input wire logic snk_valid, // popped word present
    input wire logic snk_ready, // receiver takes
    input wire ahf_pkg::ahf_pins_out_t fifo_out, // to fifo
    input wire ahf_pkg::ahf_pins_in_t fifo_in // from fifo
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    // strobe phases held through their least times
    sequence si_held;
        fifo_out.shift_in [*4];
    endsequence
    sequence so_held;
        fifo_out.shift_out [*3];
    endsequence
    mr_width_a: assert property ($rose(fifo_out.master_reset_n) |-> !$past(fifo_out.master_reset_n, 2))
        else $error("master reset pulse too short");
    mr_gap_a: assert property ($rose(fifo_out.master_reset_n) |-> !fifo_out.shift_in [*5])
        else $error("shift in too soon after reset");
    si_high_a: assert property ($rose(fifo_out.shift_in) |-> si_held)
        else $error("shift in high too short");
    si_low_a: assert property ($fell(fifo_out.shift_in) |-> !fifo_out.shift_in [*3])
        else $error("shift in low too short");
    data_hold_a: assert property ($rose(fifo_out.shift_in) |=> $stable(fifo_out.write_data_in) [*3])
        else $error("write data not held");
    si_ready_a: assert property ($rose(fifo_out.shift_in) |-> $past(fifo_in.input_ready) || $past(fifo_in.input_ready, 2))
        else $error("shift in without input ready");
    src_gate_a: assert property (src_ready |-> fifo_in.input_ready && !fifo_out.shift_in)
        else $error("source ready without room");
    so_high_a: assert property ($rose(fifo_out.shift_out) |-> so_held)
        else $error("shift out high too short");
    so_low_a: assert property ($fell(fifo_out.shift_out) |-> !fifo_out.shift_out [*3])
        else $error("shift out low too short");
    so_ready_a: assert property ($rose(fifo_out.shift_out) |-> $past(fifo_in.output_ready))
        else $error("shift out without output ready");
    snk_hold_a: assert property (snk_valid && !snk_ready |=> snk_valid && $stable(snk_data))
        else $error("sink word dropped while stalled");
endmodule
bind ahf_host ahf_host_asserts u_chk (.ref_clk, .arst_n, .src_valid, .src_ready, .snk_data, .snk_valid,
    .snk_ready, .fifo_out, .fifo_in);
`default_nettype wire

// file: tb/testbench.sv
/*
 self-checking bench: host controller against the fifo model.
 assumes 100 MHz ref_clk and the checker bound by its own file.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ahf_pkg::*;
    localparam int LIMIT = 40000;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    ahf_word_t src_data = '0;
    logic src_valid = 1'b0;
    logic snk_ready = 1'b0;
    logic reset_req = 1'b0;
    logic stall = 1'b0;
    logic src_ready;
    logic snk_valid;
    ahf_word_t snk_data;
    ahf_pins_out_t fifo_out;
    ahf_pins_in_t fifo_in;
    logic [CNT_W-1:0] level;
    logic [CNT_W-1:0] count;
    ahf_word_t exp_q [$];
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    ahf_host DUT (.ref_clk, .arst_n, .src_data, .src_valid, .src_ready, .snk_data, .snk_valid, .snk_ready,
        .reset_req, .fifo_out, .fifo_in, .level);
    ahf_fifo_model u_fifo (.ref_clk(ref_clk), .pins(fifo_out), .stall(stall), .fifo(fifo_in), .count(count));
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    // random far-side slowness and a hang limit
    always @(posedge ref_clk)
    begin
        stall <= 1'($urandom);
        cycles++;
        if (cycles == LIMIT)
        begin
            errors++;
            $display("[FAIL] %0t timeout", $time);
            end_of_test();
        end
    end
    task automatic chk_w(input ahf_word_t got, input ahf_word_t exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t count %h expected %h", $time, got, exp);
        end
    endtask
    // offer one word; a bounded wait lets a full buffer end the fill
    task automatic push(input ahf_word_t w, output bit ok);
        int n;
        n = 0;
        @(posedge ref_clk);
        src_data <= w;
        src_valid <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (src_ready !== 1'b1 && n < 300);
        ok = (src_ready === 1'b1);
        src_valid <= 1'b0;
        if (ok)
            exp_q.push_back(w);
    endtask
    // take n words under random back-pressure
    task automatic pop(input int n);
        while (n > 0)
        begin
            @(posedge ref_clk);
            if (snk_valid === 1'b1 && snk_ready === 1'b1)
            begin
                chk_w(snk_data, exp_q.pop_front());
                n--;
            end
            // one assignment per edge; the last taken word lowers ready
            snk_ready <= (n > 0) && (($urandom % 3) != 0);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        bit ok;
        int i;
        void'($urandom(32'h6b905911));
        repeat (12) @(posedge ref_clk);
        chk_n(CNT_W'(src_ready), '0);
        chk_n(CNT_W'(fifo_out.master_reset_n), '0);
        arst_n <= 1'b1;
        $display("test reset done");
        // fill with the reader stalled until the fifo refuses
        ok = 1'b1;
        i = 0;
        while (ok)
        begin
            push(i == 0 ? 5'h1f : (i == 1 ? 5'h00 : ahf_word_t'($urandom)), ok);
            i++;
        end
        chk_n(level, CNT_W'(DEPTH));
        chk_n(count, CNT_W'(DEPTH));
        $display("test fill done");
        // traffic both ways while the far side stalls
        fork
            for (int k = 0; k < 40; k++)
                push(ahf_word_t'($urandom), ok);
            pop(exp_q.size() + 40);
        join
        // the last strobe may still be ending after its word left the buffer
        repeat (10) @(posedge ref_clk);
        chk_n(level, '0);
        chk_n(CNT_W'(snk_valid), '0);
        $display("test stream done");
        // restart with words inside; held words may only leave in order
        for (int k = 0; k < 5; k++)
            push(ahf_word_t'($urandom), ok);
        // let the last strobe finish so master reset cuts no pulse short
        repeat (12) @(posedge ref_clk);
        reset_req <= 1'b1;
        @(posedge ref_clk);
        reset_req <= 1'b0;
        repeat (20) @(posedge ref_clk);
        chk_n(level, '0);
        chk_n(count, '0);
        chk_w(fifo_in.read_data_out, '0);
        snk_ready <= 1'b1;
        repeat (6)
        begin
            @(posedge ref_clk);
            if (snk_valid === 1'b1 && snk_ready === 1'b1)
                chk_w(snk_data, exp_q.pop_front());
        end
        snk_ready <= 1'b0;
        exp_q.delete();
        push(5'h15, ok);
        pop(1);
        $display("test restart done");
        end_of_test();
    end
endmodule
`default_nettype wire
